//--- hdl/init_seq_pkg.sv
/*
 Constants for the memory-side initialization sequencer: timing figures,
 command codes and state encodings.
 Assumes a single 50 MHz clock and commands decoded upstream into codes.
*/
// Contract
// R1: Controller sends calibration start only after termination mode writes finish.
// R2: Devices sharing one calibration resistor calibrate strictly one after another.
// R3: Calibration takes at least 1 us; latch command then applies the values.
// R4: After latch the bus stays quiet for max of 30 ns and 8 clocks.
// R5: Command bus training follows latch quiet; device boots with default reference.
// R6: Clock stays no faster than boot period, 18 ns, until training completes.
// R7: During command bus training, CA stream is echoed onto DQ asynchronously.
// R8: Write leveling follows; active while mode register 2 bit 7 is high.
// R9: Controller shifts strobe until device sees burst start at write latency.
// R10: DQ training uses FIFO and read-calibration commands; array is untouched.
// R11: After the sequence the device accepts any valid command.
// R12: Training steps after latch are optional and may be reordered.
// R13: Reset held low at least 200 us after supply ramp.
// R14: Clock enable low at least 10 ns before reset release.
// R15: Clock enable kept low at least 2 ms after reset release.
// R16: At least 5 stable clocks before clock enable first rises.
// R17: At least 2 us idle after clock enable before first mode command.
// R18: Warm reset pulse at least 100 ns, clock enable low 10 ns before release.
// R19: After warm reset the sequence repeats from the clock-enable wait.
// R20: Clock enable low at power-off; device outputs stay high impedance.
// R21: Reset asserted from any state puts the device into reset state.
// R22: Chip select low when clock enable first rises after reset.
// R23: Controller derives waits from counters rounded up.
package init_seq_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS            = 20000;
   localparam int IMPEDANCE_CAL_DURATION_NS = 1000;
   localparam int IMPEDANCE_LATCH_QUIET_NS  = 30;
   localparam int IMPEDANCE_LATCH_QUIET_CK  = 8;
   localparam int CAL_CYCLES =
      (IMPEDANCE_CAL_DURATION_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LATCH_NS_CYCLES =
      (IMPEDANCE_LATCH_QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LATCH_CYCLES = (LATCH_NS_CYCLES > IMPEDANCE_LATCH_QUIET_CK) ?
      LATCH_NS_CYCLES : IMPEDANCE_LATCH_QUIET_CK;
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // Command codes on cmd_code_in
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_NOP       = 4'h0;
   localparam logic [3:0] CMD_MRW       = 4'h1;
   localparam logic [3:0] CMD_MRR       = 4'h2;
   localparam logic [3:0] CMD_CAL_BEGIN = 4'h3;
   localparam logic [3:0] CMD_CAL_APPLY = 4'h4;
   localparam logic [3:0] CMD_FIFO_WR   = 4'h5;
   localparam logic [3:0] CMD_FIFO_RD   = 4'h6;
   localparam logic [3:0] CMD_RD_CAL    = 4'h7;
   localparam logic [3:0] CMD_ARRAY_WR  = 4'h8;
   localparam logic [3:0] CMD_ARRAY_RD  = 4'h9;

   // Mode register fields
   localparam logic [5:0] MR_WRLEV_ADDR = 6'h02;
   localparam int         MR_WRLEV_BIT  = 7;
   localparam logic [5:0] MR_CBT_ADDR   = 6'h0D;
   localparam int         MR_CBT_BIT    = 0;

   // ----------------------------------------------------------------
   // Device states
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_RESET  = 7'h01,
      ST_WAIT   = 7'h02,
      ST_IDLE   = 7'h04,
      ST_CAL    = 7'h08,
      ST_LATCH  = 7'h10,
      ST_CBT    = 7'h20,
      ST_WRLEV  = 7'h40
   } dev_state_e;

endpackage : init_seq_pkg

//--- hdl/interval_counter.sv
/*
 Down counter that reports when a loaded interval has elapsed.
 Assumes the load and the clear come from the sequencer's own clock domain.
*/
`timescale 1ns/10ps
module interval_counter #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             resetn_in,
   // Control
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] count_in,
   // Status
   output logic                  done_out
);
   logic [WIDTH-1:0] remain;

   // A zero-width timer cannot count
   if (WIDTH < 1) begin : g_width_check
      $error("timer width must be at least one bit");
   end

   // Count down to zero after a load
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         remain <= '0;
      else if (load_in)
         remain <= count_in;
      else if (remain != '0)
         remain <= remain - WIDTH'(1);
   end

   assign done_out = (remain == '0) && !load_in;
endmodule : interval_counter

//--- hdl/init_sequencer.sv
/*
 Memory-side sequencer for reset, impedance calibration, training modes
 and normal operation. Commands arrive already decoded as codes.
 Assumes the controller keeps all controller-side timing; flags misuse only.
*/
`timescale 1ns/10ps
module init_sequencer
   import init_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // Memory pins seen by the device
   input  wire logic        mem_resetn_in,
   input  wire logic        cke_in,
   input  wire logic        cs_in,
   input  wire logic [3:0]  cmd_code_in,
   input  wire logic [5:0]  mr_addr_in,
   input  wire logic [7:0]  mr_data_in,
   input  wire logic [5:0]  ca_in,
   // DQ pins
   output logic [7:0]       dq_out,
   output logic [7:0]       dq_oe_out,
   // Status
   output logic             ready_out,
   output logic             cal_busy_out,
   output logic             calibrated_out,
   output logic             cbt_mode_out,
   output logic             wrlev_mode_out,
   output logic             array_write_out,
   output logic             cmd_error_out,
   output logic [6:0]       state_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dev_state_e         state;
   dev_state_e         next_state;
   logic [CNT_W-1:0]   cal_age;
   logic               cal_done;
   logic               latch_done;
   logic               load_cal;
   logic               load_latch;
   logic               cmd_error;
   logic               array_write;

   // Timer counts must fit the counter width
   if (CAL_CYCLES >= (1 << CNT_W) || LATCH_CYCLES < 1) begin : g_count_check
      $error("interval counts do not fit the timer width");
   end

   // Command decoding
   wire cmd_valid  = cke_in && cs_in && (cmd_code_in != CMD_NOP);
   wire is_mrw     = cmd_valid && (cmd_code_in == CMD_MRW);
   wire is_begin   = cmd_valid && (cmd_code_in == CMD_CAL_BEGIN);
   wire is_apply   = cmd_valid && (cmd_code_in == CMD_CAL_APPLY);
   wire is_array_w = cmd_valid && (cmd_code_in == CMD_ARRAY_WR);
   wire cbt_set    = is_mrw && (mr_addr_in == MR_CBT_ADDR) && mr_data_in[MR_CBT_BIT];
   wire cbt_clr    = is_mrw && (mr_addr_in == MR_CBT_ADDR) && !mr_data_in[MR_CBT_BIT];
   wire wrl_set    = is_mrw && (mr_addr_in == MR_WRLEV_ADDR) && mr_data_in[MR_WRLEV_BIT];
   wire wrl_clr    = is_mrw && (mr_addr_in == MR_WRLEV_ADDR) && !mr_data_in[MR_WRLEV_BIT];

   // ----------------------------------------------------------------
   // Interval timers
   // ----------------------------------------------------------------
   assign load_cal   = (state == ST_IDLE) && is_begin;
   assign load_latch = (state == ST_CAL) && cal_done && is_apply;

   // Calibration time
   interval_counter #(.WIDTH(CNT_W)) cal_timer (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in && mem_resetn_in),
      .load_in    (load_cal),
      .count_in   (CNT_W'(CAL_CYCLES)),                // [R3]
      .done_out   (cal_done)
   );

   // Latch quiet time, reuses timer logic
   interval_counter #(.WIDTH(CNT_W)) latch_timer (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in && mem_resetn_in),
      .load_in    (load_latch),
      .count_in   (CNT_W'(LATCH_CYCLES - 1)),          // [R4] load cycle is the first
      .done_out   (latch_done)
   );

   // Cycles spent in calibration, saturating, for the minimum-time check
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in || state != ST_CAL)
         cal_age <= '0;
      else if (cal_age != '1)
         cal_age <= cal_age + CNT_W'(1);
   end

   // ----------------------------------------------------------------
   // State transitions
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      cmd_error  = 1'b0;
      unique case (state)
         ST_RESET: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (cke_in)
               next_state = ST_IDLE;                   // [R19]
         end
         ST_IDLE: begin
            if (is_begin)
               next_state = ST_CAL;
            else if (cbt_set)
               next_state = ST_CBT;                    // [R5] [R12]
            else if (wrl_set)
               next_state = ST_WRLEV;                  // [R8]
         end
         ST_CAL: begin
            if (is_apply && cal_done)
               next_state = ST_LATCH;                  // [R3]
            else if (cmd_valid)
               cmd_error = 1'b1;                       // [R3]
         end
         ST_LATCH: begin
            if (cmd_valid)
               cmd_error = 1'b1;                       // [R4]
            if (latch_done)
               next_state = ST_IDLE;
         end
         ST_CBT: begin
            if (cbt_clr)
               next_state = ST_IDLE;
         end
         ST_WRLEV: begin
            if (wrl_clr)
               next_state = ST_IDLE;                   // [R8]
         end
      endcase
      if (!mem_resetn_in)
         next_state = ST_RESET;                        // [R21]
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         state <= ST_RESET;
      else
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // Calibration result and status flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in || !mem_resetn_in) begin
         calibrated_out <= 1'b0;
         cmd_error_out  <= 1'b0;
      end else begin
         if (state == ST_LATCH && latch_done) begin
            calibrated_out <= 1'b1;                    // [R3]
         end
         cmd_error_out <= cmd_error;
      end
   end

   // Array writes only from real write commands, never training
   assign array_write = is_array_w && (state == ST_IDLE);   // [R10]

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in)
         array_write_out <= 1'b0;
      else
         array_write_out <= array_write && mem_resetn_in;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // CA echo on DQ is combinational, i.e. asynchronous to the clock
   assign dq_out    = (state == ST_CBT) ? {2'h0, ca_in} : 8'h00;   // [R7]
   assign dq_oe_out = (cke_in && mem_resetn_in && state == ST_CBT)
                      ? 8'hFF : 8'h00;                          // [R20]
   assign ready_out      = (state == ST_IDLE);                     // [R11]
   assign cal_busy_out   = (state == ST_CAL) || (state == ST_LATCH);
   assign cbt_mode_out   = (state == ST_CBT);
   assign wrlev_mode_out = (state == ST_WRLEV);
   assign state_out      = state;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   reset_enters_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      !mem_resetn_in |=> state == ST_RESET)                   // [R21]
      else $error("reset pin did not force reset state");

   cal_min_time_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_IDLE && next_state == ST_CAL) |=> (state == ST_CAL)[*8])  // [R3]
      else $error("calibration ended too early");

   cal_age_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_CAL && next_state == ST_LATCH) |-> cal_age >= CNT_W'(CAL_CYCLES)) // [R3]
      else $error("calibration latched before its time");

   latch_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_CAL && next_state == ST_LATCH) |=> (state == ST_LATCH)[*8]) // [R4]
      else $error("latch quiet too short");

   hiz_cke_low_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      !cke_in |-> dq_oe_out == 8'h00)                          // [R20]
      else $error("DQ driven while clock enable low");

   cbt_echo_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      state == ST_CBT |-> dq_out[5:0] == ca_in)                // [R7]
      else $error("CA not echoed on DQ");

   wrlev_bit_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_IDLE && wrl_set && !is_begin && !cbt_set && mem_resetn_in)
      |=> wrlev_mode_out)                                      // [R8]
      else $error("write leveling not entered");

   no_array_wr_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state != ST_IDLE) |=> !array_write_out)                 // [R10]
      else $error("array write outside normal operation");

   ready_idle_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_LATCH && latch_done && mem_resetn_in) |=> ready_out && calibrated_out) // [R11]
      else $error("not ready after latch");

   wait_cke_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (state == ST_WAIT && !cke_in && mem_resetn_in) |=> state == ST_WAIT) // [R19]
      else $error("left wait before clock enable");

endmodule : init_sequencer

//--- test/ctrl_model.sv
/*
 Controller-side model that drives the memory pins of the sequencer.
 Assumes the bench calls its tasks from one process, just after a rising edge.
*/
`timescale 1ns/10ps
module ctrl_model
   import init_seq_pkg::*;
#(
   parameter int CKE_WAIT = 20, // Scaled enable-low wait after release
   parameter int IDLE_CYC = 5   // Scaled idle before first mode command
) (
   // Clock
   input  wire logic       ref_clk_in,
   // Memory pins
   output logic            mem_resetn_out,
   output logic            cke_out,
   output logic            cs_out,
   output logic [3:0]      cmd_out,
   output logic [5:0]      mr_addr_out,
   output logic [7:0]      mr_data_out,
   output logic [5:0]      ca_out
);
   // Pins start quiet with the device held in reset
   initial begin
      mem_resetn_out = 1'b0;
      cke_out        = 1'b0;
      cs_out         = 1'b0;
      cmd_out        = CMD_NOP;
      mr_addr_out    = 6'h00;
      mr_data_out    = 8'h00;
      ca_out         = 6'h00;
   end

   // Wait whole cycles counted on our own clock
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : idle

   // Enable low first, then reset pin low for n cycles
   task automatic pin_reset(input int n);
      cke_out = 1'b0;
      idle(1);
      mem_resetn_out = 1'b0;
      idle(n);
   endtask : pin_reset

   // Release reset and keep enable low with the clock running
   task automatic release_reset();
      mem_resetn_out = 1'b1;
      idle(CKE_WAIT);
   endtask : release_reset

   // Raise enable with chip select low, then stay idle
   task automatic enable();
      cs_out = 1'b0;
      cke_out = 1'b1;
      idle(IDLE_CYC);
   endtask : enable

   // One command held for one edge, then released
   task automatic issue(input logic [3:0] cmd, input logic [5:0] a, input logic [7:0] d);
      idle(1); // Let an edge pass after any earlier release
      cs_out = 1'b1;
      cmd_out = cmd;
      mr_addr_out = a;
      mr_data_out = d;
      idle(1);
      cs_out = 1'b0;
      cmd_out = CMD_NOP;
      mr_addr_out = ~a; // Released lines do not keep the last value
      mr_data_out = ~d;
   endtask : issue

   // Put a value on the CA bus for command bus training
   task automatic set_ca(input logic [5:0] v);
      ca_out = v;
   endtask : set_ca

   // Move clock enable on its own
   task automatic set_cke(input logic v);
      cke_out = v;
   endtask : set_cke
endmodule : ctrl_model

//--- test/init_sequencer_test.sv
/*
 Self-checking bench for the memory-side initialization sequencer.
 Assumes the controller model in ctrl_model.sv and the design package.
*/
`timescale 1ns/10ps
module init_sequencer_test;
   import init_seq_pkg::*;

   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic mem_resetn, cke, cs;
   logic [3:0] cmd;
   logic [5:0] mr_addr, ca;
   logic [7:0] mr_data, dq, dq_oe;
   logic ready, cal_busy, calibrated, cbt_mode, wrlev_mode, array_write, cmd_error;
   logic [6:0] state;
   int failures = 0;
   int total_checks = 0;

   // 20 ns clock, slower than the boot limit
   always #10 ref_clk_in = ~ref_clk_in;

   ctrl_model ctl (.ref_clk_in(ref_clk_in), .mem_resetn_out(mem_resetn), .cke_out(cke),
      .cs_out(cs), .cmd_out(cmd), .mr_addr_out(mr_addr), .mr_data_out(mr_data), .ca_out(ca));

   init_sequencer DUT (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .mem_resetn_in(mem_resetn), .cke_in(cke), .cs_in(cs), .cmd_code_in(cmd),
      .mr_addr_in(mr_addr), .mr_data_in(mr_data), .ca_in(ca), .dq_out(dq),
      .dq_oe_out(dq_oe), .ready_out(ready), .cal_busy_out(cal_busy),
      .calibrated_out(calibrated), .cbt_mode_out(cbt_mode), .wrlev_mode_out(wrlev_mode),
      .array_write_out(array_write), .cmd_error_out(cmd_error), .state_out(state));

   // ----------------------------------------------------------------
   // Comparisons and closing
   // ----------------------------------------------------------------
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_flag

   task automatic end_sim();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_power_up();
      ctl.pin_reset(10);
      check_val({1'b0, state}, {1'b0, ST_RESET});
      ctl.release_reset();
      check_val({1'b0, state}, {1'b0, ST_WAIT});
      check_val(dq_oe, 8'h00);
      ctl.enable();
      check_flag(ready, 1'b1);
      $display("t_power_up done");
   endtask : t_power_up

   task automatic t_cal();
      int n;
      ctl.issue(CMD_MRW, 6'h0B, 8'h00);
      ctl.issue(CMD_CAL_BEGIN, 6'h00, 8'h00);
      check_flag(cal_busy, 1'b1);
      ctl.idle(9);
      ctl.issue(CMD_CAL_APPLY, 6'h00, 8'h00);
      check_flag(cmd_error, 1'b1);
      check_val({1'b0, state}, {1'b0, ST_CAL});
      ctl.idle(40);
      ctl.issue(CMD_CAL_APPLY, 6'h00, 8'h00);
      check_flag(cmd_error, 1'b0);
      n = 0;
      while (state === ST_LATCH && n < 20) begin
         ctl.idle(1);
         n++;
      end
      check_val(8'(n), 8'h08);
      check_val({1'b0, state}, {1'b0, ST_IDLE});
      check_flag(calibrated, 1'b1);
      $display("t_cal done");
   endtask : t_cal

   task automatic t_cbt();
      logic [5:0] v;
      ctl.issue(CMD_MRW, MR_CBT_ADDR, 8'h01);
      check_flag(cbt_mode, 1'b1);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 6'h15 : (i == 1) ? 6'h2A : 6'h3F;
         ctl.set_ca(v);
         @(negedge ref_clk_in);
         check_val(dq, {2'h0, v});
         check_val(dq_oe, 8'hFF);
         ctl.idle(1);
      end
      ctl.set_cke(1'b0);
      @(negedge ref_clk_in);
      check_val(dq_oe, 8'h00);
      ctl.idle(1);
      ctl.set_cke(1'b1);
      ctl.issue(CMD_MRW, MR_CBT_ADDR, 8'h00);
      check_val({1'b0, state}, {1'b0, ST_IDLE});
      $display("t_cbt done");
   endtask : t_cbt

   task automatic t_wrlev();
      ctl.issue(CMD_MRW, MR_WRLEV_ADDR, 8'h80);
      check_flag(wrlev_mode, 1'b1);
      check_val(dq_oe, 8'h00);
      ctl.idle(3);
      check_flag(wrlev_mode, 1'b1);
      ctl.issue(CMD_MRW, MR_WRLEV_ADDR, 8'h00);
      check_flag(wrlev_mode, 1'b0);
      $display("t_wrlev done");
   endtask : t_wrlev

   task automatic t_normal();
      ctl.issue(CMD_ARRAY_WR, 6'h00, 8'h00);
      check_flag(array_write, 1'b1);
      for (int c = 5; c < 8; c++) begin
         ctl.issue(4'(c), 6'h00, 8'h00);
         check_flag(array_write, 1'b0);
         check_flag(cmd_error, 1'b0);
      end
      ctl.issue(CMD_ARRAY_RD, 6'h00, 8'h00);
      check_flag(ready, 1'b1);
      $display("t_normal done");
   endtask : t_normal

   task automatic t_warm();
      ctl.issue(CMD_MRW, MR_CBT_ADDR, 8'h01);
      ctl.pin_reset(5);
      check_val({1'b0, state}, {1'b0, ST_RESET});
      check_flag(calibrated, 1'b0);
      check_val(dq_oe, 8'h00);
      ctl.release_reset();
      ctl.enable();
      check_val({1'b0, state}, {1'b0, ST_IDLE});
      $display("t_warm done");
   endtask : t_warm

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk_in);
      #1 resetn_in = 1'b1;
      t_power_up();
      t_cal();
      t_cbt();
      t_wrlev();
      t_normal();
      t_warm();
      end_sim();
   end

   initial begin
      #(20 * 5000);
      failures++;
      end_sim();
   end
endmodule : init_sequencer_test
